// File: rtl/flash_rww_pkg.sv
/*
 Constants for the self-programming access control of the on-chip program
 flash: word address layout, fixed read-while-write split, loader sizes,
 protection bit coding and programming duration.
 Assumes a word-addressed flash of 8K words, paged for erase and write only.
*/
package flash_rww_pkg;
	localparam int          ADDR_W         = 13;
	localparam int          PAGE_W         = 6;       // Words per page, as address bits
	localparam int          CNT_W          = 16;
	// Fixed split: everything from here upward never allows read-while-write
	localparam logic [12:0] NO_READ_WHILE_WRITE_REGION_START     = 13'h1C00;
	// Loader start address for each of the four loader size fuse codes
	localparam logic [12:0] LOADER_START_0 = 13'h1C00;
	localparam logic [12:0] LOADER_START_1 = 13'h1E00;
	localparam logic [12:0] LOADER_START_2 = 13'h1F00;
	localparam logic [12:0] LOADER_START_3 = 13'h1F80;
	// Protection pair: bit 0 programmed (low) forbids writes to the section
	localparam logic [1:0]  LOCK_ERASED    = 2'h3;
	localparam int          LOCK_WR_BIT    = 0;
	// Page erase or page write duration in clock cycles
	localparam logic [15:0] PROG_CYCLES    = 16'h00C8;
	// Store-program command codes
	localparam logic [1:0]  OP_ERASE       = 2'h0;
	localparam logic [1:0]  OP_WRITE       = 2'h1;
	localparam logic [1:0]  OP_LOCK        = 2'h2;
	localparam logic [1:0]  OP_REENABLE    = 2'h3;
	// Control and status bit positions
	localparam int          ST_BUSY_BIT    = 6;
	localparam int          ST_REEN_BIT    = 4;
	localparam int          ST_LOCK_BIT    = 3;
	localparam int          ST_WRITE_BIT   = 2;
	localparam int          ST_ERASE_BIT   = 1;
	localparam int          ST_ACTIVE_BIT  = 0;

	typedef enum logic [2:0] {
		ST_IDLE      = 3'h1,
		ST_PROG_RWW  = 3'h2,
		ST_PROG_NO_READ_WHILE_WRITE_REGION = 3'h4
	} prog_state_e;
endpackage

// File: rtl/region_if.sv
/*
 Carrier between the access controller and its address decoder.
 Assumes the controller drives the addresses and the fuse code.
*/
`timescale 1ns/10ps
interface region_if;
	import flash_rww_pkg::*;
	logic [ADDR_W-1:0] pc_addr;
	logic [ADDR_W-1:0] tgt_addr;
	logic [ADDR_W-1:0] fetch_addr;
	logic [1:0]        size_fuse;
	logic              pc_in_loader;
	logic              tgt_in_loader;
	logic              tgt_in_rww;
	logic              fetch_in_rww;
	modport dec (input pc_addr, tgt_addr, fetch_addr, size_fuse,
		output pc_in_loader, tgt_in_loader, tgt_in_rww, fetch_in_rww);
	modport ctl (output pc_addr, tgt_addr, fetch_addr, size_fuse,
		input pc_in_loader, tgt_in_loader, tgt_in_rww, fetch_in_rww);
endinterface

// File: rtl/region_decode.sv
/*
 Address decoder: loader section from the size fuses, fixed region split.
 Assumes purely combinational use by the access controller.
*/
`timescale 1ns/10ps
module region_decode (
	// Decoder side of the carrier
	region_if.dec rif
);
	import flash_rww_pkg::*;

	logic [ADDR_W-1:0] loader_start;

	// Loader boundary comes only from the fuse field, never from run-time state
	assign loader_start = (rif.size_fuse == 2'h0) ? LOADER_START_0 :
		(rif.size_fuse == 2'h1) ? LOADER_START_1 :
		(rif.size_fuse == 2'h2) ? LOADER_START_2 : LOADER_START_3;
	assign rif.pc_in_loader  = rif.pc_addr >= loader_start;
	assign rif.tgt_in_loader = rif.tgt_addr >= loader_start;
	// Fixed split; every loader start sits at or above it
	assign rif.tgt_in_rww    = rif.tgt_addr < NO_READ_WHILE_WRITE_REGION_START;
	assign rif.fetch_in_rww  = rif.fetch_addr < NO_READ_WHILE_WRITE_REGION_START;
endmodule // region_decode

// File: rtl/flash_rww_ctrl.sv
/*
 Self-programming access control for the program flash: starts page erase
 and write from the loader only, applies per-section protection, halts the
 core or blocks read-while-write region fetches, keeps the region-busy flag.
 Assumes a core that presents fetches and store-program requests on mclk,
 and a flash macro that accepts one start pulse per page operation.
*/
// Operation
// - Store-program starts erase or write only when executed from the loader section
// - Loader store-program may target any page, loader section included
// - Application/loader boundary comes from the loader size fuses only
// - Application and loader sections obey separate protection bit pairs
// - Fixed read-while-write and no-read-while-write regions split by address
// - Programming the read-while-write region keeps core running, serves other region
// - Programming the no-read-while-write region halts the core, nothing readable
// - Read-while-write region never returns code during loader programming
// - Loader section always lies inside the no-read-while-write region
// - Region-busy flag reads one while read-while-write region is blocked
// - Busy flag stays set after programming until software clears it
// - Halt or not is chosen by the target address, not the read address
// - Page grouping affects erase and write only, never fetches
// - Region-busy flag is read-only bit 6 of the control and status byte
// - Protection bits set by software or programmer, cleared by chip erase or reset only
`timescale 1ns/10ps
module flash_rww_ctrl (
	// Clock, reset, enable
	input  wire logic                          mclk,
	input  wire logic                          srst,
	input  wire logic                          ce,
	// Fuses
	input  wire logic [1:0]                    loader_size_fuses,
	// Core fetch port
	input  wire logic                          fetch_req,
	input  wire logic [flash_rww_pkg::ADDR_W-1:0] fetch_addr,
	output logic                               fetch_grant,
	output logic                               core_halt,
	// Core store-program request
	input  wire logic                          store_program_instruction,
	input  wire logic [1:0]                    store_op,
	input  wire logic [flash_rww_pkg::ADDR_W-1:0] store_pc,
	input  wire logic [flash_rww_pkg::ADDR_W-1:0] store_addr,
	input  wire logic [3:0]                    store_lock_val,
	// External programming interface
	input  wire logic                          ext_lock_set,
	input  wire logic [3:0]                    ext_lock_val,
	input  wire logic                          chip_erase,
	// Flash macro command
	output logic                               flash_start,
	output logic                               flash_erase,
	output logic [flash_rww_pkg::ADDR_W-flash_rww_pkg::PAGE_W-1:0] flash_page,
	// Status
	output logic                               region_busy_flag,
	output logic [7:0]                         store_program_ctrl_status,
	output logic [3:0]                         lock_bits
);
	import flash_rww_pkg::*;

	region_if rif ();

	prog_state_e       state_reg, state_next;
	logic [CNT_W-1:0]  cnt_reg;
	logic              busy_reg;
	logic [1:0]        app_lock_reg;
	logic [1:0]        ldr_lock_reg;
	logic              start_reg;
	logic              erase_reg;
	logic [ADDR_W-PAGE_W-1:0] page_reg;
	logic [1:0]        last_op_reg;

	wire idle      = state_reg == ST_IDLE;
	wire req       = ce & store_program_instruction & idle;
	wire from_ldr  = rif.pc_in_loader;
	wire is_prog   = (store_op == OP_ERASE) | (store_op == OP_WRITE);
	wire tgt_open  = rif.tgt_in_loader ? ldr_lock_reg[LOCK_WR_BIT]
		: app_lock_reg[LOCK_WR_BIT];
	wire go_prog   = req & from_ldr & is_prog & tgt_open;
	wire go_lock   = req & from_ldr & (store_op == OP_LOCK);
	wire go_reen   = req & from_ldr & (store_op == OP_REENABLE);
	wire cnt_done  = cnt_reg == PROG_CYCLES - 16'h0001;
	wire in_prog   = ~idle;

	// Decoder hookup
	assign rif.pc_addr    = store_pc;
	assign rif.tgt_addr   = store_addr;
	assign rif.fetch_addr = fetch_addr;
	assign rif.size_fuse  = loader_size_fuses;

	region_decode i_region_decode (
		.rif (rif.dec)
	);

	// Next state: region choice from the target address only
	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			ST_IDLE: begin
				if (go_prog)
					state_next = rif.tgt_in_rww ? ST_PROG_RWW : ST_PROG_NO_READ_WHILE_WRITE_REGION;
			end
			ST_PROG_RWW: begin
				if (cnt_done)
					state_next = ST_IDLE;
			end
			ST_PROG_NO_READ_WHILE_WRITE_REGION: begin
				if (cnt_done)
					state_next = ST_IDLE;
			end
			default: state_next = ST_IDLE;
		endcase
	end

	// State and duration counter
	always_ff @(posedge mclk) begin
		if (srst) begin
			state_reg <= ST_IDLE;
			cnt_reg   <= '0;
		end else if (ce) begin
			state_reg <= state_next;
			cnt_reg   <= (in_prog & ~cnt_done) ? cnt_reg + 16'h0001 : '0;
		end
	end

	// Busy flag: a new start wins over a re-enable in the same cycle
	always_ff @(posedge mclk) begin
		if (srst)
			busy_reg <= 1'b0;
		else if (ce) begin
			if (go_prog)
				busy_reg <= 1'b1;
			else if (go_reen)
				busy_reg <= 1'b0;
		end
	end

	// Protection pairs only move toward programmed except on chip erase or reset
	always_ff @(posedge mclk) begin
		if (srst) begin
			app_lock_reg <= LOCK_ERASED;
			ldr_lock_reg <= LOCK_ERASED;
		end else if (ce) begin
			if (chip_erase) begin
				app_lock_reg <= LOCK_ERASED;
				ldr_lock_reg <= LOCK_ERASED;
			end else if (go_lock) begin
				app_lock_reg <= app_lock_reg & store_lock_val[1:0];
				ldr_lock_reg <= ldr_lock_reg & store_lock_val[3:2];
			end else if (ext_lock_set) begin
				app_lock_reg <= app_lock_reg & ext_lock_val[1:0];
				ldr_lock_reg <= ldr_lock_reg & ext_lock_val[3:2];
			end
		end
	end

	// Flash command; the page field drops the in-page word bits
	always_ff @(posedge mclk) begin
		if (srst) begin
			start_reg   <= 1'b0;
			erase_reg   <= 1'b0;
			page_reg    <= '0;
			last_op_reg <= OP_ERASE;
		end else if (ce) begin
			start_reg <= go_prog;
			if (go_prog) begin
				erase_reg   <= store_op == OP_ERASE;
				page_reg    <= store_addr[ADDR_W-1:PAGE_W];
				last_op_reg <= store_op;
			end
		end
	end

	// Fetch path ignores pages; it only looks at region and busy state
	assign core_halt   = state_reg == ST_PROG_NO_READ_WHILE_WRITE_REGION;
	assign fetch_grant = fetch_req & ~core_halt
		& ~(busy_reg & rif.fetch_in_rww);

	assign flash_start      = start_reg;
	assign flash_erase      = erase_reg;
	assign flash_page       = page_reg;
	assign region_busy_flag = busy_reg;
	assign lock_bits        = {ldr_lock_reg, app_lock_reg};

	// Status byte, busy bit read-only
	always_comb begin
		store_program_ctrl_status                = 8'h00;
		store_program_ctrl_status[ST_BUSY_BIT]   = busy_reg;
		store_program_ctrl_status[ST_ACTIVE_BIT] = in_prog;
		store_program_ctrl_status[ST_ERASE_BIT]  = in_prog & (last_op_reg == OP_ERASE);
		store_program_ctrl_status[ST_WRITE_BIT]  = in_prog & (last_op_reg == OP_WRITE);
	end

	// Checks
	a_app_no_start: assert property (@(posedge mclk) disable iff (srst)
		(ce & store_program_instruction & ~rif.pc_in_loader) |=> ~flash_start)
		else $error("store from application section started flash");
	a_ldr_start: assert property (@(posedge mclk) disable iff (srst)
		(req & rif.pc_in_loader & is_prog & tgt_open) |=> flash_start)
		else $error("loader store did not start flash");
	a_lock_block: assert property (@(posedge mclk) disable iff (srst)
		(req & ~tgt_open) |=> ~flash_start)
		else $error("protected section was programmed");
	a_no_read_while_write_region_halt: assert property (@(posedge mclk) disable iff (srst)
		(go_prog & ~rif.tgt_in_rww) |=> (core_halt & ~fetch_grant) [*8])
		else $error("core not halted for no-rww programming");
	a_rww_run: assert property (@(posedge mclk) disable iff (srst)
		(go_prog & rif.tgt_in_rww) |=> ~core_halt)
		else $error("core halted for rww programming");
	a_rww_blocked: assert property (@(posedge mclk) disable iff (srst)
		(busy_reg & rif.fetch_in_rww) |-> ~fetch_grant)
		else $error("rww code returned while busy");
	a_busy_hold: assert property (@(posedge mclk) disable iff (srst)
		(busy_reg & ce & ~go_reen) |=> busy_reg)
		else $error("busy flag dropped without clear");
	a_busy_set: assert property (@(posedge mclk) disable iff (srst)
		go_prog |=> region_busy_flag & store_program_ctrl_status[ST_BUSY_BIT])
		else $error("busy flag not set on start");
	a_halt_end: assert property (@(posedge mclk) disable iff (srst)
		(core_halt & ce & cnt_done) |=> ~core_halt)
		else $error("core not released after programming");
	a_ldr_no_read_while_write_region: assert property (@(posedge mclk) disable iff (srst)
		rif.pc_in_loader |-> (store_pc >= NO_READ_WHILE_WRITE_REGION_START))
		else $error("loader section outside no-rww region");

	c_rww_prog: cover property (@(posedge mclk) go_prog & rif.tgt_in_rww);
	c_no_read_while_write_region_prog: cover property (@(posedge mclk) go_prog & ~rif.tgt_in_rww);
	c_reenable: cover property (@(posedge mclk) busy_reg & go_reen);
	c_lock_set: cover property (@(posedge mclk) go_lock);
endmodule // flash_rww_ctrl

// File: tb/core_model.sv
/*
 Core model: code fetches and store-program requests toward the flash control.
 Assumes a bench that calls its tasks; all lines change at the falling edge.
*/
`timescale 1ns/10ps
module core_model (
	// Clock
	input  wire logic                             mclk,
	// Fetch side
	output logic                                  fetch_req,
	output logic [flash_rww_pkg::ADDR_W-1:0]      fetch_addr,
	input  wire logic                             fetch_grant,
	// Store side
	output logic                                  store_program_instruction,
	output logic [1:0]                            store_op,
	output logic [flash_rww_pkg::ADDR_W-1:0]      store_pc,
	output logic [flash_rww_pkg::ADDR_W-1:0]      store_addr,
	output logic [3:0]                            store_lock_val
);
	import flash_rww_pkg::*;
	// Idle core at time zero
	initial begin
		fetch_req = 1'b0;
		fetch_addr = 13'h0000;
		store_program_instruction = 1'b0;
		{store_op, store_pc, store_addr, store_lock_val} = '0;
	end
	// One-cycle store; fields inverted after, so stale values never match
	task automatic store(input logic [1:0] op, input logic [12:0] pc, a, input logic [3:0] lv);
		@(negedge mclk);
		{store_op, store_pc, store_addr, store_lock_val} = {op, pc, a, lv};
		store_program_instruction = 1'b1;
		@(negedge mclk);
		store_program_instruction = 1'b0;
		{store_op, store_pc, store_addr, store_lock_val} = ~{op, pc, a, lv};
	endtask
	// Fetch probe; a busy-region fetch happens only when the bench asks
	task automatic fetch(input logic [12:0] a, output logic g);
		@(negedge mclk);
		fetch_req = 1'b1;
		fetch_addr = a;
		#2 g = fetch_grant;
		@(negedge mclk);
		fetch_req = 1'b0;
		fetch_addr = ~a;
	endtask
endmodule // core_model

// File: tb/testbench.sv
/*
 Testbench for the self-programming flash access control.
 Assumes the core model in its own file and the package constants.
*/
`timescale 1ns/10ps
module testbench;
	import flash_rww_pkg::*;
	logic        mclk, srst, ce, ext_lock_set, chip_erase, g;
	logic [1:0]  loader_size_fuses;
	logic [3:0]  ext_lock_val, store_lock_val, lock_bits;
	logic        fetch_req, fetch_grant, core_halt, store_program_instruction;
	logic        flash_start, flash_erase, region_busy_flag;
	logic [1:0]  store_op;
	logic [12:0] fetch_addr, store_pc, store_addr;
	logic [6:0]  flash_page;
	logic [7:0]  store_program_ctrl_status;
	logic [12:0] ls [4] = '{LOADER_START_0, LOADER_START_1, LOADER_START_2, LOADER_START_3};
	int          bad_count, check_count;
	// Clock
	initial begin
		mclk = 1'b0;
		forever #10 mclk = ~mclk;
	end
	flash_rww_ctrl i_flash_rww_ctrl (.mclk(mclk), .srst(srst), .ce(ce),
		.loader_size_fuses(loader_size_fuses), .fetch_req(fetch_req),
		.fetch_addr(fetch_addr), .fetch_grant(fetch_grant), .core_halt(core_halt),
		.store_program_instruction(store_program_instruction), .store_op(store_op),
		.store_pc(store_pc), .store_addr(store_addr), .store_lock_val(store_lock_val),
		.ext_lock_set(ext_lock_set), .ext_lock_val(ext_lock_val), .chip_erase(chip_erase),
		.flash_start(flash_start), .flash_erase(flash_erase), .flash_page(flash_page),
		.region_busy_flag(region_busy_flag),
		.store_program_ctrl_status(store_program_ctrl_status), .lock_bits(lock_bits));
	core_model i_core_model (.mclk(mclk), .fetch_req(fetch_req), .fetch_addr(fetch_addr),
		.fetch_grant(fetch_grant), .store_program_instruction(store_program_instruction),
		.store_op(store_op), .store_pc(store_pc), .store_addr(store_addr),
		.store_lock_val(store_lock_val));
	// Compare, four-state exact
	task automatic chk(input logic [7:0] got, exp, input string m);
		check_count++;
		if (got !== exp) begin
			bad_count++;
			$display("wrong value at %0t: %s got %h exp %h", $time, m, got, exp);
		end
	endtask
	task automatic test_done;
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// Store, then look at the one-cycle start pulse where it stands
	task automatic issue(input logic [1:0] op, input logic [12:0] pc, a, input logic [3:0] lv,
		input logic es);
		i_core_model.store(op, pc, a, lv);
		chk(flash_start, es, "start pulse");
	endtask
	// Bounded wait for the page operation to end
	task automatic finish_op;
		for (int i = 0; i < 300 && store_program_ctrl_status[ST_ACTIVE_BIT]; i++)
			@(negedge mclk);
		if (store_program_ctrl_status[ST_ACTIVE_BIT] !== 1'b0) begin
			bad_count++;
			$display("wrong value at %0t: operation hangs", $time);
			test_done();
		end
	endtask
	task automatic fetch_chk(input logic [12:0] a, input logic e);
		i_core_model.fetch(a, g);
		chk(g, e, "fetch grant");
	endtask
	// Main sequence
	initial begin
		{srst, ce, ext_lock_set, chip_erase} = 4'h3 << 2;
		loader_size_fuses = 2'h2;
		ext_lock_val = 4'hF;
		repeat (20) @(negedge mclk);
		srst = 1'b0;
		chk(store_program_ctrl_status, 8'h00, "status reset");
		chk(lock_bits, 8'h0F, "lock reset");
		issue(OP_ERASE, 13'h0100, 13'h0040, 4'hF, 1'b0);
		issue(OP_ERASE, 13'h1F90, 13'h0040, 4'hF, 1'b1);
		chk({flash_erase, flash_page}, 8'h81, "erase page");
		chk(store_program_ctrl_status, 8'h43, "rww status");
		chk(core_halt, 1'b0, "rww no halt");
		fetch_chk(13'h1C10, 1'b1);
		fetch_chk(13'h0010, 1'b0);
		issue(OP_WRITE, 13'h1F90, 13'h0080, 4'hF, 1'b0);
		finish_op();
		chk(store_program_ctrl_status, 8'h40, "busy held");
		fetch_chk(13'h0010, 1'b0);
		issue(OP_REENABLE, 13'h1F90, 13'h0000, 4'hF, 1'b0);
		chk(region_busy_flag, 1'b0, "busy cleared");
		fetch_chk(13'h0010, 1'b1);
		$display("test rww done");
		issue(OP_WRITE, 13'h1F90, 13'h1F80, 4'hF, 1'b1);
		chk(core_halt, 1'b1, "no_read_while_write_region halt");
		chk(store_program_ctrl_status, 8'h45, "no_read_while_write_region status");
		fetch_chk(13'h1C10, 1'b0);
		finish_op();
		chk(core_halt, 1'b0, "core released");
		$display("test no_read_while_write_region done");
		for (int f = 0; f < 4; f++) begin
			loader_size_fuses = f[1:0];
			issue(OP_ERASE, ls[f] - 13'h0001, 13'h1C00, 4'hF, 1'b0);
			issue(OP_ERASE, ls[f], 13'h1C00, 4'hF, 1'b1);
			finish_op();
		end
		$display("test fuses done");
		issue(OP_LOCK, 13'h1F90, 13'h0000, 4'hE, 1'b0);
		finish_op();
		chk(lock_bits, 8'h0E, "lock set");
		issue(OP_ERASE, 13'h1F90, 13'h0040, 4'hF, 1'b0);
		issue(OP_WRITE, 13'h1F90, 13'h1F80, 4'hF, 1'b1);
		finish_op();
		ext_lock_val = 4'hB;
		ext_lock_set = 1'b1;
		@(negedge mclk);
		ext_lock_set = 1'b0;
		chk(lock_bits, 8'h0A, "ext lock");
		issue(OP_ERASE, 13'h1F90, 13'h1F80, 4'hF, 1'b0);
		chip_erase = 1'b1;
		@(negedge mclk);
		chip_erase = 1'b0;
		chk(lock_bits, 8'h0F, "chip erase");
		// Enable low: a busy clear must not be taken
		ce = 1'b0;
		issue(OP_REENABLE, 13'h1F90, 13'h0000, 4'hF, 1'b0);
		chk(region_busy_flag, 1'b1, "frozen busy");
		ce = 1'b1;
		issue(OP_LOCK, 13'h0100, 13'h0000, 4'h0, 1'b0);
		chk(lock_bits, 8'h0F, "app lock refused");
		$display("test locks done");
		test_done();
	end
endmodule // testbench
